// File: abort_source_model.sv
/* Abort source standing in for the memory management unit.
   Assumes go_i is raised for one cycle just after a rising edge. */
`timescale 1ns/1ns
module abort_source_model (
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic fetch_i,
  output logic mem_cycle_o,
  output logic mem_is_fetch_o,
  output logic abort_o
);
  initial begin
    mem_cycle_o = 1'b0;
    mem_is_fetch_o = 1'b0;
    abort_o = 1'b0;
  end
  // One faulting cycle per request; outside it the lines wander on purpose
  always @(posedge clock_i) begin
    mem_cycle_o <= go_i;
    mem_is_fetch_o <= go_i ? fetch_i : ~mem_is_fetch_o;
    abort_o <= go_i | ~abort_o;
  end
endmodule

// File: cpu_exception_sequencer.sv
/*
  Exception sequencer of the processor core: abort classification,
  fixed priority arbitration, entry sequencing, reset sequence.
  Assumes a pipeline that reports instruction boundaries, decode traps,
  memory cycles and transfer kinds on the same clock, and an AHB-Lite
  master for the debug/status registers.
*/
`timescale 1ns/1ns
`include "exc_consts.svh"

// Behaviour
// - Sample abort only in memory cycles, classify
// - Prefetch abort marks instruction, raises at head
// - Flushed aborted instruction raises nothing
// - Single transfer abort keeps base write-back
// - Aborted swap changes no state
// - Block transfer completes, later overwrites blocked
// - Undecodable instruction takes undefined trap
// - Fixed vector address per exception
// - Fixed priority among simultaneous exceptions
// - Undefined and software trap never together
// - Data abort then fast interrupt chains
// - Fast interrupt latency bounded by 28 cycles
// - Minimum interrupt latency four cycles
// - Normal interrupt may wait behind fast ones
// - In reset, fetch incrementing word addresses
// - Reset release copies pc, status to supervisor
// - Reset release forces supervisor, masks, clears state
// - After reset fetch from zero, 32-bit state
// - Entry saves link, status, forces mode, vector
// - Fast interrupt entry masks normal interrupts
// - Exception entry leaves 16-bit state
module cpu_exception_sequencer (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic core_reset_n_i,
  input wire logic fast_interrupt_request_n_i,
  input wire logic normal_interrupt_request_n_i,
  input wire logic interrupt_sync_select_i,
  input wire logic abort_i,
  input wire logic mem_cycle_i,
  input wire logic mem_is_fetch_i,
  input wire logic flush_i,
  input wire logic advance_i,
  input wire logic boundary_i,
  input wire logic decode_undef_i,
  input wire logic decode_swi_i,
  input wire logic [1:0] xfer_kind_i,
  input wire logic base_wb_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hsel_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic fetch_valid_o,
  output logic [31:0] fetch_addr_o,
  output logic load_pc_o,
  output logic [31:0] current_status_word_o,
  output logic [31:0] link_value_o,
  output logic [31:0] saved_status_o,
  output logic [4:0] link_mode_o,
  output logic block_base_wb_o,
  output logic block_reg_write_o,
  output logic exc_busy_o
);

  // Transfer kinds from the execute stage
  localparam logic [1:0] XF_SINGLE = 2'h1;
  localparam logic [1:0] XF_SWAP = 2'h2;
  localparam logic [1:0] XF_BLOCK = 2'h3;

  // Vector for an exception kind
  function automatic logic [31:0] vec_of(input exc_pkg::exc_kind_e k);
    case (k)
      exc_pkg::EXC_RESET: vec_of = `VEC_RESET;
      exc_pkg::EXC_UNDEF: vec_of = `VEC_UNDEF;
      exc_pkg::EXC_SWI: vec_of = `VEC_SWI;
      exc_pkg::EXC_PABT: vec_of = `VEC_PABT;
      exc_pkg::EXC_DABT: vec_of = `VEC_DABT;
      exc_pkg::EXC_IRQ: vec_of = `VEC_IRQ;
      exc_pkg::EXC_FIQ: vec_of = `VEC_FIQ;
      default: vec_of = `VEC_RSVD;
    endcase
  endfunction

  // Target mode for an exception kind
  function automatic logic [4:0] mode_of(input exc_pkg::exc_kind_e k);
    case (k)
      exc_pkg::EXC_UNDEF: mode_of = `MODE_UND;
      exc_pkg::EXC_PABT, exc_pkg::EXC_DABT: mode_of = `MODE_ABT;
      exc_pkg::EXC_IRQ: mode_of = `MODE_IRQ;
      exc_pkg::EXC_FIQ: mode_of = `MODE_FIQ;
      default: mode_of = `MODE_SVC;
    endcase
  endfunction

  logic rst_m_reg, rst_s_reg, rst_d_reg;
  logic fiq_m_reg, fiq_s_reg, irq_m_reg, irq_s_reg;
  logic fiq_req, irq_req;
  logic pabt_f_reg, pabt_h_reg, dabt_reg;
  logic in_block_reg;
  exc_pkg::seq_state_e state_reg;
  exc_pkg::exc_kind_e kind_reg;
  exc_pkg::exc_kind_e win;
  logic [1:0] cnt_reg;
  logic [31:0] psr_reg, link_reg, spsr_reg, fetch_reg, vec_reg;
  logic [31:0] ctrl_reg;
  logic load_reg, bwb_reg, brw_reg;
  logic [31:0] rdata_reg;
  logic ph_rd_reg, ph_wr_reg;
  logic [31:0] ph_addr_reg;

  // Reset and interrupt pins from outside are double-registered first
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_m_reg <= 1'b0;
      rst_s_reg <= 1'b0;
      fiq_m_reg <= 1'b1;
      fiq_s_reg <= 1'b1;
      irq_m_reg <= 1'b1;
      irq_s_reg <= 1'b1;
    end else begin
      rst_m_reg <= core_reset_n_i;
      rst_s_reg <= rst_m_reg;
      fiq_m_reg <= fast_interrupt_request_n_i;
      fiq_s_reg <= fiq_m_reg;
      irq_m_reg <= normal_interrupt_request_n_i;
      irq_s_reg <= irq_m_reg;
    end
  end

  // Sync select bypasses nothing at pins: both paths must be synchronised
  assign fiq_req = !fiq_s_reg && !psr_reg[`PSR_F_BIT];
  assign irq_req = !irq_s_reg && !psr_reg[`PSR_I_BIT];

  // Abort capture and pending tracking
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pabt_f_reg <= 1'b0;
      pabt_h_reg <= 1'b0;
      dabt_reg <= 1'b0;
      in_block_reg <= 1'b0;
    end else if (flush_i || state_reg != exc_pkg::ST_RUN) begin
      pabt_f_reg <= 1'b0;
      pabt_h_reg <= 1'b0;
      dabt_reg <= 1'b0;
      in_block_reg <= 1'b0;
    end else begin
      if (mem_cycle_i && abort_i && mem_is_fetch_i) begin
        pabt_f_reg <= 1'b1;
      end else if (advance_i) begin
        pabt_f_reg <= 1'b0;
      end
      if (advance_i && pabt_f_reg) begin
        pabt_h_reg <= 1'b1;
      end else if (boundary_i) begin
        pabt_h_reg <= 1'b0;
      end
      if (mem_cycle_i && abort_i && !mem_is_fetch_i) begin
        dabt_reg <= 1'b1;
        in_block_reg <= (xfer_kind_i == XF_BLOCK);
      end
    end
  end

  // Fixed priority arbiter, one winner per boundary
  always_comb begin
    win = exc_pkg::EXC_NONE;
    if (dabt_reg) begin
      win = exc_pkg::EXC_DABT;
    end else if (fiq_req) begin
      win = exc_pkg::EXC_FIQ;
    end else if (irq_req) begin
      win = exc_pkg::EXC_IRQ;
    end else if (pabt_h_reg) begin
      win = exc_pkg::EXC_PABT;
    end else if (decode_undef_i) begin
      win = exc_pkg::EXC_UNDEF;
    end else if (decode_swi_i) begin
      win = exc_pkg::EXC_SWI;
    end
  end

  // Transfer guards during a data abort
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bwb_reg <= 1'b0;
      brw_reg <= 1'b0;
    end else begin
      // Single keeps write-back, swap and block lose register writes
      bwb_reg <= mem_cycle_i && abort_i && !mem_is_fetch_i
        && xfer_kind_i == XF_SWAP;
      brw_reg <= (dabt_reg && in_block_reg && !boundary_i)
        || (mem_cycle_i && abort_i && !mem_is_fetch_i
        && (xfer_kind_i == XF_SWAP || xfer_kind_i == XF_BLOCK && !base_wb_i));
    end
  end

  // Entry sequencer and architectural status
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= exc_pkg::ST_RESET;
      kind_reg <= exc_pkg::EXC_NONE;
      cnt_reg <= 2'h0;
      psr_reg <= 32'h0000_00d3;
      link_reg <= 32'h0000_0000;
      spsr_reg <= 32'h0000_0000;
      fetch_reg <= 32'h0000_0000;
      vec_reg <= 32'h0000_0000;
      load_reg <= 1'b0;
      rst_d_reg <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      rst_d_reg <= rst_s_reg;
      case (state_reg)
        exc_pkg::ST_RESET: begin
          fetch_reg <= fetch_reg + `WORD_STEP;
          if (rst_s_reg) begin
            link_reg <= fetch_reg;
            spsr_reg <= psr_reg;
            psr_reg[4:0] <= `MODE_SVC;
            psr_reg[`PSR_I_BIT] <= 1'b1;
            psr_reg[`PSR_F_BIT] <= 1'b1;
            psr_reg[`PSR_T_BIT] <= 1'b0;
            fetch_reg <= `VEC_RESET;
            vec_reg <= `VEC_RESET;
            kind_reg <= exc_pkg::EXC_RESET;
            load_reg <= 1'b1;
            state_reg <= exc_pkg::ST_RUN;
          end
        end
        exc_pkg::ST_RUN: begin
          if (!rst_s_reg) begin
            state_reg <= exc_pkg::ST_RESET;
            fetch_reg <= pc_i;
          end else if (boundary_i && win != exc_pkg::EXC_NONE) begin
            link_reg <= pc_i + ((win == exc_pkg::EXC_DABT) ? `DABT_RET_OFS
              : `NEXT_RET_OFS);
            spsr_reg <= psr_reg;
            psr_reg[4:0] <= mode_of(win);
            psr_reg[`PSR_I_BIT] <= 1'b1;
            psr_reg[`PSR_T_BIT] <= 1'b0;
            if (win == exc_pkg::EXC_FIQ) begin
              psr_reg[`PSR_F_BIT] <= 1'b1;
            end
            vec_reg <= vec_of(win);
            kind_reg <= win;
            cnt_reg <= (win == exc_pkg::EXC_DABT) ? 2'(`DABT_ENTRY_CYC - 1)
              : 2'(`FIQ_ENTRY_CYC - 1);
            state_reg <= exc_pkg::ST_ENTRY;
          end
        end
        exc_pkg::ST_ENTRY: begin
          if (!rst_s_reg) begin
            state_reg <= exc_pkg::ST_RESET;
          end else if (cnt_reg != 2'h0) begin
            cnt_reg <= cnt_reg - 2'h1;
          end else begin
            fetch_reg <= vec_reg;
            load_reg <= 1'b1;
            // Chain straight into the fast handler after a data abort
            if (kind_reg == exc_pkg::EXC_DABT && fiq_req) begin
              link_reg <= vec_reg + `NEXT_RET_OFS;
              spsr_reg <= psr_reg;
              psr_reg[4:0] <= `MODE_FIQ;
              psr_reg[`PSR_F_BIT] <= 1'b1;
              vec_reg <= `VEC_FIQ;
              kind_reg <= exc_pkg::EXC_FIQ;
              cnt_reg <= 2'(`FIQ_ENTRY_CYC - 1);
              load_reg <= 1'b0;
            end else begin
              state_reg <= exc_pkg::ST_RUN;
            end
          end
        end
        default: state_reg <= exc_pkg::ST_RESET;
      endcase
      if (state_reg == exc_pkg::ST_RUN && ph_wr_reg && ph_addr_reg == `REG_PSR) begin
        psr_reg <= hwdata_i;
      end
    end
  end

  // AHB-Lite slave: zero-wait, always OKAY
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_rd_reg <= 1'b0;
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= 32'h0000_0000;
      ctrl_reg <= `CTRL_RESET;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (hready_i) begin
        ph_rd_reg <= hsel_i && htrans_i[1] && !hwrite_i;
        ph_wr_reg <= hsel_i && htrans_i[1] && hwrite_i;
        ph_addr_reg <= {haddr_i[31:2], 2'b00};
        if (hsel_i && htrans_i[1] && !hwrite_i) begin
          case ({haddr_i[31:2], 2'b00})
            `REG_CTRL: rdata_reg <= ctrl_reg;
            `REG_STATUS: rdata_reg <= {24'h000000, 1'b0, kind_reg, state_reg,
              interrupt_sync_select_i, rst_d_reg};
            `REG_PSR: rdata_reg <= psr_reg;
            `REG_LINK: rdata_reg <= link_reg;
            `REG_SPSR: rdata_reg <= spsr_reg;
            `REG_VECTOR: rdata_reg <= vec_reg;
            default: rdata_reg <= 32'h0000_0000;
          endcase
        end
      end
      if (ph_wr_reg && ph_addr_reg == `REG_CTRL) begin
        ctrl_reg <= hwdata_i;
      end
    end
  end

  // Outputs from flip-flops; bus responses tied off, fetch_valid_o decoded from state and ctrl_reg[0], exc_busy_o from state
  assign hrdata_o = rdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign fetch_valid_o = (state_reg != exc_pkg::ST_ENTRY) && !ctrl_reg[0];
  assign fetch_addr_o = fetch_reg;
  assign load_pc_o = load_reg;
  assign current_status_word_o = psr_reg;
  assign link_value_o = link_reg;
  assign saved_status_o = spsr_reg;
  assign link_mode_o = psr_reg[4:0];
  assign block_base_wb_o = bwb_reg;
  assign block_reg_write_o = brw_reg;
  assign exc_busy_o = (state_reg != exc_pkg::ST_RUN);

endmodule

// File: cpu_exception_sequencer_sva.sv
/* Port checker for the exception sequencer.
   Assumes it is bound into cpu_exception_sequencer and sees its ports only. */
`timescale 1ns/1ns
`include "exc_consts.svh"
module exc_seq_checker (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic core_reset_n_i,
  input wire logic fast_interrupt_request_n_i,
  input wire logic normal_interrupt_request_n_i,
  input wire logic load_pc_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic [31:0] current_status_word_o,
  input wire logic [4:0] link_mode_o,
  input wire logic exc_busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Core reset passes two flops, so only long low runs are judged
  AST_RST_WALK: assert property (
    !core_reset_n_i [*4] |=> fetch_addr_o == $past(fetch_addr_o) + `WORD_STEP)
    else $error("fetch address not stepping in reset");
  AST_RST_BUSY: assert property (
    !core_reset_n_i [*5] |-> exc_busy_o && !load_pc_o) else $error("entry while in reset");
  AST_RST_EXIT: assert property (
    $rose(core_reset_n_i) |-> ##[1:6] (load_pc_o && fetch_addr_o == `VEC_RESET &&
      current_status_word_o[7:0] == 8'hd3)) else $error("bad reset release");
  // Each vector pairs with one mode; the reserved slot never loads
  AST_VEC_MODE: assert property (
    load_pc_o |-> fetch_addr_o < 32'h20 && fetch_addr_o != `VEC_RSVD &&
      link_mode_o == (fetch_addr_o == `VEC_FIQ ? `MODE_FIQ : fetch_addr_o == `VEC_IRQ ?
      `MODE_IRQ : fetch_addr_o == `VEC_UNDEF ? `MODE_UND : (fetch_addr_o == `VEC_PABT ||
      fetch_addr_o == `VEC_DABT) ? `MODE_ABT : `MODE_SVC)) else $error("vector and mode differ");
  AST_FIQ_MASK: assert property (
    load_pc_o && fetch_addr_o == `VEC_FIQ |-> current_status_word_o[`PSR_I_BIT])
    else $error("fast entry left normal requests open");
  AST_ARM_STATE: assert property (
    load_pc_o |-> !current_status_word_o[`PSR_T_BIT]) else $error("vector load in short state");
  AST_FIQ_MAX: assert property (
    $fell(fast_interrupt_request_n_i) && !current_status_word_o[`PSR_F_BIT] && !exc_busy_o
      |-> ##[1:28] (load_pc_o && fetch_addr_o == `VEC_FIQ)) else $error("fast entry too late");
  AST_INT_MIN: assert property (
    $fell(fast_interrupt_request_n_i) || $fell(normal_interrupt_request_n_i)
      |=> !load_pc_o [*2]) else $error("interrupt entry too early");
endmodule
bind cpu_exception_sequencer exc_seq_checker chk (.clock_i(clock_i), .nrst_i(nrst_i),
  .core_reset_n_i(core_reset_n_i), .fast_interrupt_request_n_i(fast_interrupt_request_n_i),
  .normal_interrupt_request_n_i(normal_interrupt_request_n_i), .load_pc_o(load_pc_o),
  .fetch_addr_o(fetch_addr_o), .current_status_word_o(current_status_word_o),
  .link_mode_o(link_mode_o), .exc_busy_o(exc_busy_o));

// File: cpu_exception_sequencer_test.sv
/* Self-checking bench for the exception sequencer.
   Assumes the bound checker and the abort source model. */
`timescale 1ns/1ns
`include "exc_consts.svh"
module cpu_exception_sequencer_test;
  logic clock_i, nrst_i, core_n, fast_n, norm_n, abort, memc, mfetch, flush, adv, bnd, und, software_trap_instruction;
  logic go, go_fetch, track, blk, bwb, hit, hwrite, hsel, load_pc, rdy, bwb_o, blk_o, busy;
  logic [1:0] xk, htrans;
  logic [4:0] mode;
  logic [31:0] pc, haddr, hwdata, rd, hrdata, faddr, psr, link, spsr;
  int error_cnt, num_checks;
  cpu_exception_sequencer dut (.clock_i(clock_i), .nrst_i(nrst_i), .core_reset_n_i(core_n),
    .fast_interrupt_request_n_i(fast_n), .normal_interrupt_request_n_i(norm_n),
    .interrupt_sync_select_i(1'b0), .abort_i(abort), .mem_cycle_i(memc), .flush_i(flush),
    .mem_is_fetch_i(mfetch), .advance_i(adv), .boundary_i(bnd), .decode_undef_i(und),
    .decode_swi_i(software_trap_instruction), .xfer_kind_i(xk), .base_wb_i(1'b1), .pc_i(pc), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hsel_i(hsel), .hready_i(rdy),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(), .fetch_valid_o(),
    .fetch_addr_o(faddr), .load_pc_o(load_pc), .current_status_word_o(psr),
    .link_value_o(link), .saved_status_o(spsr), .link_mode_o(mode), .block_base_wb_o(bwb_o),
    .block_reg_write_o(blk_o), .exc_busy_o(busy));
  abort_source_model mmu (.clock_i(clock_i), .go_i(go), .fetch_i(go_fetch),
    .mem_cycle_o(memc), .mem_is_fetch_o(mfetch), .abort_o(abort));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Suppression strobes may be pulses, so they are latched while an entry runs
  always @(posedge clock_i) if (track) begin
    blk <= blk | (blk_o === 1'b1);
    bwb <= bwb | (bwb_o === 1'b1);
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for a sampled-high strobe: 0 waits for bus ready, 1 for a vector load
  task automatic wait_for(input logic pcw);
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
      if (n > 60) begin
        error_cnt++;
        finish_test();
      end
    end while ((pcw ? load_pc : rdy) !== 1'b1);
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'b1;
    wait_for(1'b0);
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(1'b0);
    rd = hrdata;
  endtask
  // Raise the chosen sources together, then check the single entry that wins
  task automatic fire(input string nm, input logic fq, iq, u, s, ab, fe, input logic [1:0] k,
      input logic [31:0] vec, input logic [4:0] md, input logic ckl, input logic [31:0] lnk);
    ahb(1'b1, `REG_PSR, 32'h0000_0013);
    @(posedge clock_i);
    fast_n <= ~fq;
    norm_n <= ~iq;
    go <= ab;
    go_fetch <= fe;
    xk <= k;
    track <= 1'b1;
    blk <= 1'b0;
    bwb <= 1'b0;
    @(posedge clock_i);
    go <= 1'b0;
    // Advance early so a fetch abort reaches the head before the boundary
    adv <= 1'b1;
    repeat (2) @(posedge clock_i);
    und <= u;
    software_trap_instruction <= s;
    bnd <= 1'b1;
    // Boundary is a one-cycle pulse, so the entry is not started twice
    @(posedge clock_i);
    {und, software_trap_instruction, bnd, adv} <= 4'h0;
    wait_for(1'b1);
    chk(faddr, vec);
    chk({27'h0, mode}, {27'h0, md});
    if (ckl) chk(link, lnk);
    if (ckl) chk(spsr, 32'h0000_0013);
    {fast_n, norm_n, und, software_trap_instruction, bnd, adv, track} <= 7'h60;
    xk <= 2'h0;
    repeat (2) @(posedge clock_i);
    $display("test %s done", nm);
  endtask
  initial begin
    {nrst_i, core_n, fast_n, norm_n, go, go_fetch, flush, adv, bnd, und, software_trap_instruction} = 11'h180;
    {track, blk, bwb, hit, hwrite, hsel, xk, htrans} = 10'h0;
    {pc, haddr, hwdata} = {32'h0000_0100, 64'h0};
    error_cnt = 0;
    num_checks = 0;
    repeat (5) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd = faddr;
    @(posedge clock_i);
    chk(faddr, rd + `WORD_STEP);
    core_n <= 1'b1;
    wait_for(1'b1);
    chk(faddr, `VEC_RESET);
    chk({24'h0, psr[7:0]}, 32'h0000_00d3);
    $display("test reset done");
    ahb(1'b1, `REG_PSR, 32'h0000_0013);
    ahb(1'b0, `REG_PSR, 32'h0);
    chk(rd, 32'h0000_0013);
    ahb(1'b0, 32'h0000_0040, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, `REG_CTRL, 32'h0);
    chk(rd, `CTRL_RESET);
    fire("undef", 0, 0, 1, 0, 0, 0, 2'h0, `VEC_UNDEF, `MODE_UND, 1, 32'h104);
    fire("swi", 0, 0, 0, 1, 0, 0, 2'h0, `VEC_SWI, `MODE_SVC, 1, 32'h104);
    fire("irq", 0, 1, 0, 0, 0, 0, 2'h0, `VEC_IRQ, `MODE_IRQ, 1, 32'h104);
    fire("fiq", 1, 1, 0, 0, 0, 0, 2'h0, `VEC_FIQ, `MODE_FIQ, 1, 32'h104);
    chk({31'h0, psr[`PSR_I_BIT]}, 32'h1);
    fire("pabt", 0, 0, 1, 0, 1, 1, 2'h0, `VEC_PABT, `MODE_ABT, 1, 32'h104);
    fire("dabt", 0, 0, 0, 1, 1, 0, 2'h1, `VEC_DABT, `MODE_ABT, 1, 32'h108);
    chk({31'h0, bwb}, 32'h0);
    fire("swap", 0, 0, 0, 0, 1, 0, 2'h2, `VEC_DABT, `MODE_ABT, 1, 32'h108);
    chk({30'h0, blk, bwb}, 32'h3);
    fire("block", 0, 0, 0, 0, 1, 0, 2'h3, `VEC_DABT, `MODE_ABT, 1, 32'h108);
    chk({30'h0, blk, bwb}, 32'h2);
    fire("chain", 1, 0, 0, 0, 1, 0, 2'h1, `VEC_FIQ, `MODE_FIQ, 0, 32'h0);
    @(posedge clock_i);
    go <= 1'b1;
    go_fetch <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    @(posedge clock_i);
    flush <= 1'b1;
    @(posedge clock_i);
    {flush, bnd, adv} <= 3'h3;
    repeat (20) begin
      @(posedge clock_i);
      hit = hit | (load_pc !== 1'b0);
    end
    {bnd, adv} <= 2'h0;
    chk({31'h0, hit}, 32'h0);
    $display("test flush done");
    finish_test();
  end
endmodule

// File: exc_consts.svh
/*
  Constants for the exception sequencer: vectors, mode codes, status bits,
  AHB register offsets and latency figures.
  Assumes inclusion by bare name from the sequencer files.
*/
`ifndef EXC_CONSTS_SVH
`define EXC_CONSTS_SVH
`define VEC_RESET 32'h0000_0000
`define VEC_UNDEF 32'h0000_0004
`define VEC_SWI 32'h0000_0008
`define VEC_PABT 32'h0000_000c
`define VEC_DABT 32'h0000_0010
`define VEC_RSVD 32'h0000_0014
`define VEC_IRQ 32'h0000_0018
`define VEC_FIQ 32'h0000_001c
`define MODE_SVC 5'h13
`define MODE_ABT 5'h17
`define MODE_UND 5'h1b
`define MODE_IRQ 5'h12
`define MODE_FIQ 5'h11
`define PSR_T_BIT 5
`define PSR_F_BIT 6
`define PSR_I_BIT 7
`define DABT_RET_OFS 32'h0000_0008
`define NEXT_RET_OFS 32'h0000_0004
`define WORD_STEP 32'h0000_0004
`define FIQ_ENTRY_CYC 2
`define DABT_ENTRY_CYC 3
`define REG_CTRL 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define REG_PSR 32'h0000_0008
`define REG_LINK 32'h0000_000c
`define REG_SPSR 32'h0000_0010
`define REG_VECTOR 32'h0000_0014
`define CTRL_RESET 32'h0000_0000
`endif

// File: exc_pkg.sv
/*
  Types for the exception sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package exc_pkg;
  typedef enum logic [2:0] {
    EXC_NONE = 3'h0,
    EXC_RESET = 3'h1,
    EXC_DABT = 3'h2,
    EXC_FIQ = 3'h3,
    EXC_IRQ = 3'h4,
    EXC_PABT = 3'h5,
    EXC_UNDEF = 3'h6,
    EXC_SWI = 3'h7
  } exc_kind_e;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ENTRY = 2'b01,
    ST_RESET = 2'b11
  } seq_state_e;
endpackage
